// ---- verilog/tmc_defs.svh ----
// threshold map configuration: offsets, field positions, reset values
// assumes the includer uses these as plain constants
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

`define TMC_ADDR_W 6
`define TMC_DATA_W 24
`define TMC_SEL_W 3
`define TMC_THR_W 10
`define TMC_NUM_THR 8

`define TMC_OFF_SEL_LOW 6'h2E
`define TMC_OFF_SEL_MID 6'h2F
`define TMC_OFF_SEL_GRP 6'h30

`define TMC_RST_SEL_LOW 24'h000000
`define TMC_RST_SEL_MID 24'h000000
`define TMC_RST_SEL_GRP 24'h000000

// writable masks; everything outside reads back zero
`define TMC_MASK_SEL_LOW 24'hFFFFFF
`define TMC_MASK_SEL_MID 24'h03FFFF
`define TMC_MASK_SEL_GRP 24'h1FFFFF

// field low bit positions
`define TMC_POS_MID_A 12
`define TMC_POS_MID_B 15
`define TMC_POS_HIGH_A 0
`define TMC_POS_HIGH_B 3
`define TMC_POS_HIGH_C 6
`define TMC_POS_S0_A 9
`define TMC_POS_S0_B 12
`define TMC_POS_S1_A 15
`define TMC_POS_S1_B 18

`endif

// ---- verilog/tmc_pkg.sv ----
// threshold map configuration types
// assumes tmc_defs.svh is on the include path
`include "tmc_defs.svh"
package tmc_pkg;
    typedef logic [`TMC_SEL_W-1:0] tmc_sel_type;
    typedef logic [`TMC_THR_W-1:0] tmc_thr_type;
    typedef logic [`TMC_DATA_W-1:0] tmc_word_type;
    typedef logic [`TMC_ADDR_W-1:0] tmc_addr_type;
endpackage

// ---- verilog/tmc_thr_mux.sv ----
// selects one of the eight threshold values by a 3-bit select
// assumes threshold values arrive packed, value n at bits 10n+9..10n
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_thr_mux (
    input wire tmc_pkg::tmc_sel_type sel,
    input wire logic [`TMC_NUM_THR*`TMC_THR_W-1:0] values,
    output tmc_pkg::tmc_thr_type chosen
);
    import tmc_pkg::*;
    always_comb begin
        chosen = values[sel*`TMC_THR_W +: `TMC_THR_W];
    end
endmodule // tmc_thr_mux

// ---- verilog/tmc_map_regs.sv ----
// three select words behind the parallel register port; single-cycle write
// strobe, registered read data; applied threshold values are resolved here
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_map_regs (
    input wire logic clk_sys,
    input wire logic srst,
    input wire tmc_pkg::tmc_addr_type reg_addr,
    input wire logic reg_wr,
    input wire tmc_pkg::tmc_word_type reg_wdata,
    input wire logic reg_rd,
    output tmc_pkg::tmc_word_type reg_rdata,
    output logic reg_hit,
    input wire logic [`TMC_NUM_THR*`TMC_THR_W-1:0] thr_values,
    output tmc_pkg::tmc_sel_type input_sel [24],
    output tmc_pkg::tmc_thr_type input_thr [12],
    output tmc_pkg::tmc_sel_type group_mid_a_select,
    output tmc_pkg::tmc_sel_type group_mid_b_select,
    output tmc_pkg::tmc_sel_type group_high_a_select,
    output tmc_pkg::tmc_sel_type group_high_b_select,
    output tmc_pkg::tmc_sel_type group_high_c_select,
    output tmc_pkg::tmc_sel_type sense0_a_select,
    output tmc_pkg::tmc_sel_type sense0_b_select,
    output tmc_pkg::tmc_sel_type sense1_a_select,
    output tmc_pkg::tmc_sel_type sense1_b_select,
    output tmc_pkg::tmc_thr_type group_mid_a_thr,
    output tmc_pkg::tmc_thr_type group_mid_b_thr,
    output tmc_pkg::tmc_thr_type group_high_a_thr,
    output tmc_pkg::tmc_thr_type group_high_b_thr,
    output tmc_pkg::tmc_thr_type group_high_c_thr,
    output tmc_pkg::tmc_thr_type sense0_a_thr,
    output tmc_pkg::tmc_thr_type sense0_b_thr,
    output tmc_pkg::tmc_thr_type sense1_a_thr,
    output tmc_pkg::tmc_thr_type sense1_b_thr
);
    import tmc_pkg::*;

    tmc_word_type sel_low_r, sel_low_nxt;
    tmc_word_type sel_mid_r, sel_mid_nxt;
    tmc_word_type sel_grp_r, sel_grp_nxt;
    tmc_word_type rdata_r, rdata_nxt;

    function automatic tmc_sel_type field(input tmc_word_type w, input int pos);
        field = w[pos +: `TMC_SEL_W];
    endfunction

    always_comb begin
        sel_low_nxt = sel_low_r;
        sel_mid_nxt = sel_mid_r;
        sel_grp_nxt = sel_grp_r;
        // reserved bits are masked on write so they never steer a select
        if (reg_wr) begin
            unique case (reg_addr)
                `TMC_OFF_SEL_LOW: sel_low_nxt = reg_wdata & `TMC_MASK_SEL_LOW;
                `TMC_OFF_SEL_MID: sel_mid_nxt = reg_wdata & `TMC_MASK_SEL_MID;
                `TMC_OFF_SEL_GRP: sel_grp_nxt = reg_wdata & `TMC_MASK_SEL_GRP;
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            unique case (reg_addr)
                `TMC_OFF_SEL_LOW: rdata_nxt = sel_low_r;
                `TMC_OFF_SEL_MID: rdata_nxt = sel_mid_r;
                `TMC_OFF_SEL_GRP: rdata_nxt = sel_grp_r;
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_comb begin
        reg_hit = (reg_addr == `TMC_OFF_SEL_LOW) || (reg_addr == `TMC_OFF_SEL_MID) ||
                  (reg_addr == `TMC_OFF_SEL_GRP);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sel_low_r <= `TMC_RST_SEL_LOW;
            sel_mid_r <= `TMC_RST_SEL_MID;
            sel_grp_r <= `TMC_RST_SEL_GRP;
            rdata_r <= '0;
        end else begin
            sel_low_r <= sel_low_nxt;
            sel_mid_r <= sel_mid_nxt;
            sel_grp_r <= sel_grp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_low
            assign input_sel[k] = field(sel_low_r, 3 * k);
        end
        for (k = 0; k < 4; k++) begin : g_mid
            assign input_sel[8 + k] = field(sel_mid_r, 3 * k);
        end
        // grouped inputs carry their group's A select on the per-input view
        for (k = 12; k < 18; k++) begin : g_grp_mid
            assign input_sel[k] = group_mid_a_select;
        end
        for (k = 18; k < 24; k++) begin : g_grp_high
            assign input_sel[k] = group_high_a_select;
        end
        for (k = 0; k < 12; k++) begin : g_thr
            tmc_thr_mux u_mux (.sel(input_sel[k]), .values(thr_values), .chosen(input_thr[k]));
        end
    endgenerate

    assign group_mid_a_select = field(sel_mid_r, `TMC_POS_MID_A);
    assign group_mid_b_select = field(sel_mid_r, `TMC_POS_MID_B);
    assign group_high_a_select = field(sel_grp_r, `TMC_POS_HIGH_A);
    assign group_high_b_select = field(sel_grp_r, `TMC_POS_HIGH_B);
    assign group_high_c_select = field(sel_grp_r, `TMC_POS_HIGH_C);
    assign sense0_a_select = field(sel_grp_r, `TMC_POS_S0_A);
    assign sense0_b_select = field(sel_grp_r, `TMC_POS_S0_B);
    assign sense1_a_select = field(sel_grp_r, `TMC_POS_S1_A);
    assign sense1_b_select = field(sel_grp_r, `TMC_POS_S1_B);

    tmc_thr_mux u_mid_a (.sel(group_mid_a_select), .values(thr_values), .chosen(group_mid_a_thr));
    tmc_thr_mux u_mid_b (.sel(group_mid_b_select), .values(thr_values), .chosen(group_mid_b_thr));
    tmc_thr_mux u_high_a (.sel(group_high_a_select), .values(thr_values), .chosen(group_high_a_thr));
    tmc_thr_mux u_high_b (.sel(group_high_b_select), .values(thr_values), .chosen(group_high_b_thr));
    tmc_thr_mux u_high_c (.sel(group_high_c_select), .values(thr_values), .chosen(group_high_c_thr));
    tmc_thr_mux u_s0_a (.sel(sense0_a_select), .values(thr_values), .chosen(sense0_a_thr));
    tmc_thr_mux u_s0_b (.sel(sense0_b_select), .values(thr_values), .chosen(sense0_b_thr));
    tmc_thr_mux u_s1_a (.sel(sense1_a_select), .values(thr_values), .chosen(sense1_a_thr));
    tmc_thr_mux u_s1_b (.sel(sense1_b_select), .values(thr_values), .chosen(sense1_b_thr));
endmodule // tmc_map_regs

// ---- tb/tmc_map_monitor.sv ----
// checker: select fields follow register writes
// assumes one clock, synchronous srst, bound into tmc_map_regs
`timescale 1ns/1ps
module tmc_map_monitor (
    input wire logic clk_sys,
    input wire logic srst,
    input wire tmc_pkg::tmc_addr_type reg_addr,
    input wire logic reg_wr,
    input wire tmc_pkg::tmc_word_type reg_wdata,
    input wire logic [79:0] thr_values,
    input wire tmc_pkg::tmc_sel_type input_sel [24],
    input wire tmc_pkg::tmc_thr_type input_thr [12],
    input wire tmc_pkg::tmc_sel_type group_mid_b_select,
    input wire tmc_pkg::tmc_sel_type group_high_c_select,
    input wire tmc_pkg::tmc_sel_type sense1_b_select
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence wr_low; reg_wr && reg_addr == 6'h2E; endsequence
    sequence wr_mid; reg_wr && reg_addr == 6'h2F; endsequence
    sequence wr_grp; reg_wr && reg_addr == 6'h30; endsequence
    low_in0_a: assert property (wr_low |=> input_sel[0] == $past(reg_wdata[2:0])) else $error("in0 sel");
    low_in7_a: assert property (wr_low |=> input_sel[7] == $past(reg_wdata[23:21])) else $error("in7 sel");
    mid_in11_a: assert property (wr_mid |=> input_sel[11] == $past(reg_wdata[11:9])) else $error("in11");
    mid_a_sel_a: assert property (wr_mid |=> input_sel[17] == $past(reg_wdata[14:12])) else $error("mid a");
    mid_b_sel_a: assert property (wr_mid |=> group_mid_b_select == $past(reg_wdata[17:15])) else $error("b");
    high_c_sel_a: assert property (wr_grp |=> group_high_c_select == $past(reg_wdata[8:6])) else $error("c");
    s1_b_sel_a: assert property (wr_grp |=> sense1_b_select == $past(reg_wdata[20:18])) else $error("s1b");
    thr_pick_a: assert property (input_thr[3] == thr_values[input_sel[3]*10+:10]) else $error("in3 thr");
endmodule // tmc_map_monitor
bind tmc_map_regs tmc_map_monitor i_mon (.*);

// ---- tb/threshold_map_config_tb.sv ----
// bench: register writes and reads against the select outputs
// assumes rising-edge sampling; inputs move on the falling edge
`timescale 1ns/1ps
module threshold_map_config_tb;
    import tmc_pkg::*;
    logic clk_sys = 0, srst = 1, reg_wr = 0, reg_rd = 0, reg_hit;
    logic [79:0] thr_values;
    tmc_addr_type reg_addr = 6'h00;
    tmc_word_type reg_wdata = 24'h000000, reg_rdata;
    tmc_sel_type input_sel [24], group_mid_a_select, group_mid_b_select, group_high_a_select, group_high_b_select;
    tmc_sel_type group_high_c_select, sense0_a_select, sense0_b_select, sense1_a_select, sense1_b_select;
    tmc_thr_type input_thr [12], group_mid_a_thr, group_mid_b_thr, group_high_a_thr, group_high_b_thr;
    tmc_thr_type group_high_c_thr, sense0_a_thr, sense0_b_thr, sense1_a_thr, sense1_b_thr;
    int error_cnt = 0, n_tests = 0;
    always #5 clk_sys = ~clk_sys;
    tmc_map_regs i_dut (.*);
    task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // one access per two cycles so no strobe is set and cleared in one step
    task automatic acc(logic wr, tmc_addr_type a, tmc_word_type d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(negedge clk_sys);
        reg_wr = 0;
        reg_rd = 0;
        if (!wr) chk("rdata", d, reg_rdata);
        @(negedge clk_sys);
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_sys);
        error_cnt++;
        complete_run();
    end
    initial begin
        for (int n = 0; n < 8; n++) thr_values[n*10+:10] = 10'(10'h0C5 + n * 123);
        repeat (16) @(negedge clk_sys);
        srst = 0;
        acc(0, 6'h2F, 24'h000000);
        chk("s1b_rst", 0, sense1_b_select);
        acc(1, 6'h2E, 24'hFAC688);
        for (int k = 0; k < 8; k++) chk("in_thr", thr_values[k*10+:10], input_thr[k]);
        acc(0, 6'h2E, 24'hFAC688);
        acc(1, 6'h2F, 24'hFEE29C);
        chk("mid_ab", 6'h2E, {group_mid_b_select, group_mid_a_select});
        chk("in12_sel", 3'h6, input_sel[12]);
        chk("mid_b_thr", thr_values[59:50], group_mid_b_thr);
        chk("in11_8", 12'h29C, {input_sel[11], input_sel[10], input_sel[9], input_sel[8]});
        acc(0, 6'h2F, 24'h02E29C);
        $display("low and mid words done");
        acc(1, 6'h30, 24'hE53977);
        chk("hit_grp", 1, reg_hit);
        chk("high", 9'h177, {group_high_c_select, group_high_b_select, group_high_a_select});
        chk("in23_sel", 3'h7, input_sel[23]);
        chk("high_a_thr", thr_values[79:70], group_high_a_thr);
        chk("sense", 12'h29C, {sense1_b_select, sense1_a_select, sense0_b_select, sense0_a_select});
        chk("s1b_thr", thr_values[19:10], sense1_b_thr);
        acc(1, 6'h31, 24'hFFFFFF);
        chk("hit_none", 0, reg_hit);
        acc(0, 6'h31, 24'h000000);
        acc(0, 6'h30, 24'h053977);
        $display("group word and unmapped done");
        srst = 1;
        @(negedge clk_sys);
        srst = 0;
        chk("grp_rst", 0, {sense1_b_select, group_high_a_select, input_sel[7]});
        chk("thr_rst", thr_values[9:0], input_thr[7]);
        acc(0, 6'h30, 24'h000000);
        $display("mid-run reset done");
        complete_run();
    end
endmodule // threshold_map_config_tb
